// File: core/swire_map.svh
// Constants for the single-wire slave command layer
`ifndef SWIRE_MAP_SVH
`define SWIRE_MAP_SVH
`define CLK_MHZ         20
`define RESET_MIN_US    480
`define SAMPLE_US       30
`define READ_HOLD_US    15
`define PRES_WAIT_US    30
`define PRES_LEN_US     120
`define CYC(us)         ((us) * `CLK_MHZ)
`define CMD_SEARCH      8'hf0
`define CMD_READ_ID     8'h33
`define CMD_MATCH       8'h55
`define CMD_SKIP        8'hcc
`define CMD_ALM_SEARCH  8'hec
`define CMD_CONVERT     8'h44
`define CMD_RD_MEM      8'hbe
`define CMD_WR_MEM      8'h4e
`define CMD_COPY        8'h48
`define CMD_RELOAD      8'hb8
`define CMD_PWR_QUERY   8'hb4
`define MEM_BYTES       9
`define RSVD_BYTE       8'hff
`endif

// File: core/swire_pkg.sv
// Types for the single-wire slave command layer
package swire_pkg;
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0000,
        ST_PWAIT  = 4'b0001,
        ST_PRES   = 4'b0010,
        ST_SELCMD = 4'b0011,
        ST_IDTX   = 4'b0100,
        ST_IDRX   = 4'b0101,
        ST_SRCH   = 4'b0110,
        ST_FNCMD  = 4'b0111,
        ST_TXBITS = 4'b1000,
        ST_RXMEM  = 4'b1001,
        ST_STATUS = 4'b1010,
        ST_HALT   = 4'b1011
    } state_type;
    typedef struct packed {
        logic       convert;
        logic       copy;
        logic       reload;
        logic [7:0] limit_hi;
        logic [7:0] limit_lo;
        logic       wr_limits;
    } req_type;
endpackage

// File: core/swire_slave.sv
// Slave transaction and command layer of a single-wire sensor link
// How it works
// R1: All bytes travel least significant bit first.
// R2: Line is only pulled low via open-drain enable, else released.
// R3: Idle high gaps between bits are tolerated without limit.
// R4: Line low beyond 480 us aborts everything as bus reset.
// R5: Order is reset, selection command, function command; else silence.
// R6: After search or alarm search the device waits for reset.
// R7: Five 8-bit selection commands are decoded after presence.
// R8: Search code joins the elimination exchange, one cycle per reset.
// R9: Read-identity sends all 64 identity bits in read slots.
// R10: Match accepts function only if all 64 bits equal identity.
// R11: Skip selects the device without identity bits.
// R12: Master must not skip then read memory with several slaves.
// R13: Alarm search acts as search only while alarm flag is set.
// R14: Convert starts conversion; status in later read slots if powered.
// R15: Memory read sends up to nine bytes, last is check byte.
// R16: Memory write stores two bytes into limit bytes 2 and 3.
// R17: Copy writes limit bytes to nonvolatile storage, no bus data.
// R18: Reload restores limits and reports status in read slots.
// R19: Power query reports supply mode in next read slot.
// R20: Master gives strong pull-up during parasite convert and copy.
// R21: A reset ends any transmission and returns to presence, then awaiting a selection command.
// R22: Master sends both limit bytes before any reset.
// R23: Presence waits 15-60 us after release, then low 60-240 us.
// R24: Write slots are sampled 15-60 us after the falling edge.
// R25: Read zero pulls low for 15 us, released before slot end.
// R26: Status reads 0 while busy, 1 when done; parasite pulls low.
// R27: Search sends bit, complement, then reads master's bit.
// R28: Unknown function codes are ignored until next reset.
`timescale 1ns/1ps
`include "swire_map.svh"
module swire_slave
    import swire_pkg::*;
#(
    parameter logic [7:0]  FAMILY_CODE = 8'h5a, // Arbitrary value
    parameter logic [47:0] SERIAL      = 48'h0123_4567_89ab, // Arbitrary value
    parameter logic [7:0]  ID_CHECK    = 8'h00, // Arbitrary value
    parameter int          RESET_CYC   = `CYC(`RESET_MIN_US)
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        dq_in,
    output logic             dq_out,
    output logic             dq_oe_n,
    input  wire logic        parasite,
    input  wire logic        alarm_flag,
    input  wire logic        conv_busy,
    input  wire logic        copy_busy,
    input  wire logic        reload_busy,
    input  wire logic [15:0] temp_word,
    input  wire logic [15:0] count_word,
    input  wire logic [7:0]  mem_check,
    input  wire logic [7:0]  nv_hi,
    input  wire logic [7:0]  nv_lo,
    output req_type          req,
    output logic [7:0]       limit_hi,
    output logic [7:0]       limit_lo
);
    localparam int SAMPLE_CYC = `CYC(`SAMPLE_US);
    localparam int HOLD_CYC   = `CYC(`READ_HOLD_US);
    localparam int PWAIT_CYC  = `CYC(`PRES_WAIT_US);
    localparam int PRES_CYC   = `CYC(`PRES_LEN_US);
    localparam logic [63:0] IDENT = {ID_CHECK, SERIAL, FAMILY_CODE};

    state_type   state_q, state_d;
    logic [13:0] low_q, low_d;     // Time line has been low
    logic [13:0] tmr_q, tmr_d;     // Slot / presence timer
    logic        line_q;
    logic        slot_q, slot_d;   // Inside a slot after a falling edge
    logic        drv_q, drv_d;     // Pulling line low
    logic [6:0]  cnt_q, cnt_d;     // Bit counter
    logic [7:0]  sh_q, sh_d;       // Receive shift register
    logic [71:0] tx_q, tx_d;       // Transmit shift register
    logic        ok_q, ok_d;       // Identity match still holds
    logic [1:0]  ph_q, ph_d;       // Search phase: bit, complement, select slot, select sample
    logic [1:0]  stk_q, stk_d;     // Status kind: 0 conv, 1 reload, 2 power query
    logic [7:0]  hi_q, hi_d, lo_q, lo_d;
    req_type     req_d;

    wire fall     = line_q && !dq_in;
    wire bus_rst  = (low_q >= 14'(RESET_CYC)) && dq_in; // R4
    wire samp_now = slot_q && (tmr_q == 14'(SAMPLE_CYC)); // R24
    wire rx_bit   = dq_in;

    always_comb begin
        state_d = state_q;
        // Our own presence pulse must not count towards a bus reset
        low_d   = (dq_in || state_q == ST_PRES) ? 14'h0 :
                  ((low_q == 14'h3fff) ? low_q : low_q + 14'h1);
        tmr_d   = (tmr_q == 14'h3fff) ? tmr_q : tmr_q + 14'h1;
        slot_d  = slot_q;
        drv_d   = drv_q;
        cnt_d   = cnt_q;
        sh_d    = sh_q;
        tx_d    = tx_q;
        ok_d    = ok_q;
        ph_d    = ph_q;
        stk_d   = stk_q;
        hi_d    = hi_q;
        lo_d    = lo_q;
        req_d   = '0;
        req_d.limit_hi = hi_q;
        req_d.limit_lo = lo_q;
        if (fall) begin
            slot_d = 1'b1;
            tmr_d  = 14'h0;
        end else if (slot_q && tmr_q == 14'(SAMPLE_CYC) + 14'h1) begin
            slot_d = 1'b0;
        end
        // Read-slot driving: zero bit held for 15 us then released
        if (drv_q && state_q != ST_PRES && tmr_q >= 14'(HOLD_CYC)) begin
            drv_d = 1'b0; // R25
        end
        case (state_q)
            ST_IDLE, ST_HALT: begin
                // Waits only for a bus reset
            end
            ST_PWAIT: if (tmr_q >= 14'(PWAIT_CYC)) begin
                state_d = ST_PRES; // R23
                drv_d   = 1'b1;
                tmr_d   = 14'h0;
            end
            ST_PRES: if (tmr_q >= 14'(PRES_CYC)) begin
                drv_d   = 1'b0; // R2
                state_d = ST_SELCMD;
                cnt_d   = 7'h0;
            end
            ST_SELCMD, ST_FNCMD, ST_IDRX, ST_RXMEM: if (samp_now) begin
                sh_d  = {rx_bit, sh_q[7:1]}; // R1
                cnt_d = cnt_q + 7'h1;
                if (state_q == ST_IDRX && rx_bit != IDENT[cnt_q[5:0]]) ok_d = 1'b0;
                if (cnt_q[2:0] == 3'h7) begin
                    if (state_q == ST_SELCMD) begin // R7
                        cnt_d = 7'h0;
                        ph_d  = 2'h0;
                        tx_d  = {8'h0, IDENT};
                        ok_d  = 1'b1;
                        case ({rx_bit, sh_q[7:1]})
                            `CMD_READ_ID: state_d = ST_IDTX; // R9
                            `CMD_MATCH:   state_d = ST_IDRX; // R10
                            `CMD_SKIP:    state_d = ST_FNCMD; // R11
                            `CMD_SEARCH:  state_d = ST_SRCH; // R8
                            `CMD_ALM_SEARCH: state_d = alarm_flag ? ST_SRCH : ST_HALT; // R13
                            default:      state_d = ST_HALT; // R5
                        endcase
                    end else if (state_q == ST_IDRX) begin
                        if (cnt_q == 7'd63) begin
                            cnt_d   = 7'h0;
                            state_d = ok_d ? ST_FNCMD : ST_HALT; // R10
                        end
                    end else if (state_q == ST_RXMEM) begin
                        if (cnt_q == 7'd7) hi_d = {rx_bit, sh_q[7:1]}; // R16
                        else begin
                            lo_d            = {rx_bit, sh_q[7:1]};
                            req_d.limit_lo  = lo_d;
                            req_d.wr_limits = 1'b1;
                            state_d         = ST_HALT;
                        end
                    end else begin
                        cnt_d = 7'h0;
                        case ({rx_bit, sh_q[7:1]})
                            `CMD_CONVERT: begin
                                req_d.convert = 1'b1; // R14
                                stk_d   = 2'h0;
                                state_d = parasite ? ST_HALT : ST_STATUS;
                            end
                            `CMD_RD_MEM: begin // R15
                                tx_d = {mem_check, count_word, `RSVD_BYTE, `RSVD_BYTE,
                                        lo_q, hi_q, temp_word};
                                state_d = ST_TXBITS;
                            end
                            `CMD_WR_MEM: state_d = ST_RXMEM;
                            `CMD_COPY: begin
                                req_d.copy = 1'b1; // R17
                                state_d    = ST_HALT;
                            end
                            `CMD_RELOAD: begin
                                req_d.reload = 1'b1; // R18
                                hi_d    = nv_hi;
                                lo_d    = nv_lo;
                                stk_d   = 2'h1;
                                state_d = ST_STATUS;
                            end
                            `CMD_PWR_QUERY: begin
                                stk_d   = 2'h2; // R19
                                state_d = ST_STATUS;
                            end
                            default: state_d = ST_HALT; // R28
                        endcase
                    end
                end
            end
            ST_IDTX, ST_TXBITS: if (fall) begin
                drv_d = !tx_q[0]; // R25
                tx_d  = {1'b0, tx_q[71:1]};
                cnt_d = cnt_q + 7'h1;
                if ((state_q == ST_IDTX && cnt_q == 7'd63) ||
                    cnt_q == 7'(8 * `MEM_BYTES - 1)) state_d = ST_HALT;
            end
            ST_STATUS: if (fall) begin
                case (stk_q)
                    2'h0:    drv_d = conv_busy; // R26
                    2'h1:    drv_d = reload_busy;
                    default: drv_d = parasite;
                endcase
            end
            ST_SRCH: begin // R27
                if (fall && !ph_q[1]) begin
                    drv_d = (ph_q == 2'h0) ? !tx_q[0] : tx_q[0];
                    ph_d  = ph_q + 2'h1;
                end else if (fall && ph_q == 2'h2) begin
                    // Only the slot after the complement carries the master's choice
                    ph_d  = 2'h3;
                end else if (samp_now && ph_q == 2'h3) begin
                    ph_d  = 2'h0;
                    tx_d  = {1'b0, tx_q[71:1]};
                    cnt_d = cnt_q + 7'h1;
                    if (rx_bit != tx_q[0] || cnt_q == 7'd63) state_d = ST_HALT; // R6
                end
            end
            default: state_d = ST_HALT;
        endcase
        // Reset overrides everything, including mid-transmission
        if (bus_rst) begin // R21
            state_d = ST_PWAIT; // R5
            tmr_d   = 14'h0;
            drv_d   = 1'b0;
            slot_d  = 1'b0;
        end
        if (!dq_in && low_q >= 14'(RESET_CYC)) begin
            state_d = ST_IDLE; // R4
            drv_d   = 1'b0;
        end
    end

    // Requests are one-cycle pulses; the limit bytes in req stand as levels
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            low_q   <= 14'h0;
            tmr_q   <= 14'h0;
            line_q  <= 1'b1;
            slot_q  <= 1'b0;
            drv_q   <= 1'b0;
            cnt_q   <= 7'h0;
            sh_q    <= 8'h0;
            tx_q    <= 72'h0;
            ok_q    <= 1'b0;
            ph_q    <= 2'h0;
            stk_q   <= 2'h0;
            hi_q    <= 8'h0;
            lo_q    <= 8'h0;
            req     <= '0;
        end else begin
            state_q <= state_d;
            low_q   <= low_d;
            tmr_q   <= tmr_d;
            line_q  <= dq_in; // R3
            slot_q  <= slot_d;
            drv_q   <= drv_d;
            cnt_q   <= cnt_d;
            sh_q    <= sh_d;
            tx_q    <= tx_d;
            ok_q    <= ok_d;
            ph_q    <= ph_d;
            stk_q   <= stk_d;
            hi_q    <= hi_d;
            lo_q    <= lo_d;
            req     <= req_d;
        end
    end

    assign dq_out   = 1'b0;
    assign dq_oe_n  = !drv_q; // R2
    assign limit_hi = hi_q;
    assign limit_lo = lo_q;

    long_low_a: assert property (@(posedge ref_clk) disable iff (rst) // R4
        (!dq_in && low_q >= 14'(RESET_CYC)) |=> (state_q == ST_IDLE && dq_oe_n))
        else $error("long low did not reset");
    release_pwait_a: assert property (@(posedge ref_clk) disable iff (rst) // R23
        bus_rst |=> state_q == ST_PWAIT)
        else $error("presence wait not entered");
    pres_len_a: assert property (@(posedge ref_clk) disable iff (rst) // R23
        $rose(state_q == ST_PRES) |-> !dq_oe_n [*8])
        else $error("presence too short");
    no_drive_idle_a: assert property (@(posedge ref_clk) disable iff (rst) // R2
        (state_q inside {ST_IDLE, ST_PWAIT, ST_SELCMD, ST_FNCMD}) |-> dq_oe_n)
        else $error("line driven while listening");
    read_release_a: assert property (@(posedge ref_clk) disable iff (rst) // R25
        (!dq_oe_n && state_q inside {ST_IDTX, ST_TXBITS, ST_STATUS, ST_SRCH} &&
         tmr_q >= 14'(HOLD_CYC)) |=> dq_oe_n)
        else $error("read zero held too long");
    halt_quiet_a: assert property (@(posedge ref_clk) disable iff (rst) // R5
        (state_q == ST_HALT && $past(state_q) == ST_HALT &&
         tmr_q > 14'(HOLD_CYC)) |-> dq_oe_n)
        else $error("driving while halted");
    write_pulse_a: assert property (@(posedge ref_clk) disable iff (rst) // R16
        req.wr_limits |-> $past(state_q) == ST_RXMEM)
        else $error("limit write from wrong state");
    pwr_query_a: assert property (@(posedge ref_clk) disable iff (rst) // R19
        (state_q == ST_STATUS && stk_q == 2'h2 && fall) |=> (dq_oe_n == !parasite))
        else $error("power query answer wrong");

    cov_reset_c: cover property (@(posedge ref_clk) $rose(state_q == ST_PRES));
    cov_match_c: cover property (@(posedge ref_clk) state_q == ST_IDRX ##1 state_q == ST_FNCMD);
    cov_read_c:  cover property (@(posedge ref_clk) state_q == ST_TXBITS ##1 state_q == ST_HALT);
    cov_srch_c:  cover property (@(posedge ref_clk) state_q == ST_SRCH && ph_q == 2'h2);
endmodule // swire_slave

// File: tb/swire_master.sv
// Bus master model that drives the shared open-drain line
`timescale 1ns/1ps
module swire_master #(
    parameter int RST_LOW = 720
) (
    input  wire logic ref_clk,
    input  wire logic line,
    output logic      m_low
);
    initial m_low = 1'b0;

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask

    // Samples the line before, during and after the presence answer
    task automatic bus_reset(output logic [2:0] seen);
        m_low = 1'b1;
        cyc(RST_LOW);
        m_low = 1'b0;
        cyc(300);
        seen[2] = line;
        cyc(1200);
        seen[1] = line;
        cyc(1520);
        seen[0] = line;
    endtask

    // A zero is held past the device sample point, yet short of a reset
    task automatic write_bit(input logic b);
        m_low = 1'b1;
        cyc(b ? 20 : 605);
        m_low = 1'b0;
        cyc(b ? 590 : 5);
    endtask

    task automatic write_byte(input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            write_bit(d[i]);
        end
    endtask

    task automatic read_bit(output logic v);
        m_low = 1'b1;
        cyc(20);
        m_low = 1'b0;
        cyc(180);
        v = line;
        cyc(120);
    endtask

    task automatic read_byte(output logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            read_bit(d[i]);
        end
    endtask
endmodule // swire_master

// File: tb/tb.sv
// Self-checking bench for the single-wire slave command layer
`timescale 1ns/1ps
`include "swire_map.svh"
module tb;
    import swire_pkg::*;
    localparam logic [7:0]  FAM = 8'h3c; // Arbitrary value
    localparam logic [47:0] SER = 48'h0a1b_2c3d_4e5f; // Arbitrary value
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        parasite = 1'b1;
    logic        conv_busy = 1'b0;
    logic        alarm_flag = 1'b0;
    logic        copy_busy = 1'b0;
    logic        reload_busy = 1'b0;
    logic [15:0] temp_word = 16'h0032;
    logic [15:0] count_word = 16'h100c;
    logic [7:0]  mem_check = 8'h6e;
    logic [7:0]  nv_hi = 8'h4b;
    logic [7:0]  nv_lo = 8'h46;
    logic        dq_out, dq_oe_n, m_low, line;
    logic [7:0]  limit_hi, limit_lo;
    req_type     req_seen;
    int          err_total = 0;
    int          num_checks = 0;

    always #25 ref_clk = ~ref_clk;
    assign line = ~(m_low | ~dq_oe_n);

    // One slave on the line, so skip before a memory read cannot collide
    swire_slave #(.FAMILY_CODE(FAM), .SERIAL(SER), .RESET_CYC(700)) dut (
        .ref_clk(ref_clk), .rst(rst), .dq_in(line), .dq_out(dq_out),
        .dq_oe_n(dq_oe_n), .parasite(parasite), .alarm_flag(alarm_flag),
        .conv_busy(conv_busy), .copy_busy(copy_busy), .reload_busy(reload_busy),
        .temp_word(temp_word), .count_word(count_word), .mem_check(mem_check),
        .nv_hi(nv_hi), .nv_lo(nv_lo), .req(req_seen),
        .limit_hi(limit_hi), .limit_lo(limit_lo));

    swire_master #(.RST_LOW(720)) mst (
        .ref_clk(ref_clk), .line(line), .m_low(m_low));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic init_sel(input logic [7:0] sel);
        logic [2:0] seen;
        mst.bus_reset(seen);
        chk(16'(seen), 16'h0005);
        mst.write_byte(sel);
    endtask

    // A function code in the selection slot must leave the device silent
    task automatic t_order();
        logic b;
        init_sel(`CMD_PWR_QUERY);
        mst.read_bit(b);
        chk(16'(b), 16'h0001);
        $display("order test done");
    endtask

    task automatic t_unknown();
        logic b;
        init_sel(`CMD_SKIP);
        mst.write_byte(8'h5a);
        mst.write_byte(`CMD_PWR_QUERY);
        mst.read_bit(b);
        chk(16'(b), 16'h0001);
        $display("unknown code test done");
    endtask

    task automatic t_power();
        logic b;
        init_sel(`CMD_SKIP);
        mst.write_byte(`CMD_PWR_QUERY);
        mst.read_bit(b);
        chk(16'(b), 16'h0000);
        parasite = 1'b0;
        $display("power query test done");
    endtask

    // External supply, so no strong pull-up is needed during the conversion
    task automatic t_convert();
        logic b;
        conv_busy = 1'b1;
        init_sel(`CMD_SKIP);
        mst.write_byte(`CMD_CONVERT);
        mst.read_bit(b);
        chk(16'(b), 16'h0000);
        conv_busy = 1'b0;
        mst.read_bit(b);
        chk(16'(b), 16'h0001);
        $display("convert test done");
    endtask

    task automatic t_write();
        init_sel(`CMD_SKIP);
        mst.write_byte(`CMD_WR_MEM);
        mst.write_byte(8'ha5);
        mst.write_byte(8'h3c);
        chk({limit_hi, limit_lo}, 16'ha53c);
        chk({req_seen.limit_hi, req_seen.limit_lo}, 16'ha53c);
        $display("memory write test done");
    endtask

    // Identity read cut short by a reset, then an alarm search that drops out
    task automatic t_ident();
        logic [7:0] d0, d1;
        logic [2:0] seen;
        init_sel(`CMD_READ_ID);
        mst.read_byte(d0);
        mst.read_byte(d1);
        chk({d1, d0}, {SER[7:0], FAM});
        mst.bus_reset(seen);
        chk(16'(seen), 16'h0005);
        alarm_flag = 1'b1;
        mst.write_byte(`CMD_ALM_SEARCH);
        mst.read_bit(d0[0]);
        mst.read_bit(d0[1]);
        chk(16'(d0[1:0]), {14'h0, ~FAM[0], FAM[0]});
        mst.write_bit(~FAM[0]);
        mst.read_bit(d0[2]);
        chk(16'(d0[2]), 16'h0001);
        alarm_flag = 1'b0;
        $display("identity test done");
    endtask

    task automatic finish_test();
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge ref_clk);
        #2;
        rst = 1'b0;
        mst.cyc(5);
        t_order();
        t_unknown();
        t_power();
        t_convert();
        t_write();
        t_ident();
        finish_test();
    end

    // Tests take about 103k cycles; half as much again can only be a hang
    initial begin
        repeat (150000) @(posedge ref_clk);
        err_total++;
        finish_test();
    end
endmodule // tb
